// >>> core/ddr_burst_pkg.sv
// shared constants and types for the burst ddr memory interface
`default_nettype none
package ddr_burst_pkg;

  // ==========================================================
  // geometry
  localparam int NUM_BANKS = 8;
  localparam int BANK_W = 3;
  localparam int ADDR_W = 22;
  localparam int DQ_W = 36;
  localparam int LANE_W = 18;
  localparam int WORD_W = 4;
  localparam int COL_W = 3;
  localparam int BEAT_W = 3;
  localparam int ROW_W = 4;
  localparam int MEM_W = BANK_W + WORD_W;

  // ==========================================================
  // command encoding on {we_n, ref_n} while chip select is low
  localparam logic [1:0] CMD_MODE_SET = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_REFRESH = 2'h2;
  localparam logic [1:0] CMD_READ = 2'h3;

  // ==========================================================
  // mode register: burst field sits in the low address bits
  localparam int MR_BL_LSB = 0;
  localparam logic [1:0] BL_CODE_2 = 2'h0;
  localparam logic [1:0] BL_CODE_4 = 2'h1;
  localparam logic [1:0] BL_CODE_8 = 2'h2;
  localparam logic [1:0] BL_RESET_CODE = BL_CODE_2;
  localparam logic [BEAT_W-1:0] LAST_BEAT_2 = 3'h1;
  localparam logic [BEAT_W-1:0] LAST_BEAT_4 = 3'h3;
  localparam logic [BEAT_W-1:0] LAST_BEAT_8 = 3'h7;

  // ==========================================================
  // pin bundles
  typedef struct packed {
    logic cs_n;
    logic we_n;
    logic ref_n;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
  } cmd_pins_type;

  localparam int SYNC_W = 1 + 2 + $bits(cmd_pins_type) + DQ_W;

  typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ, ST_TAIL} burst_state_type;

endpackage : ddr_burst_pkg
`default_nettype wire

// >>> core/pin_sync.sv
// three-stage per-bit synchroniser with agreement filter
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] out_reg;
  wire logic [WIDTH-1:0] out_next;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      meta_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end
    else
    begin
      meta_reg <= pin_in;
      s2_reg <= meta_reg;
      s3_reg <= s2_reg;
    end
  end

  // a bit moves only once stages two and three agree
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    assign out_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : out_reg[i];
  end

  // one process owns the whole vector, so no bit has two writers
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      out_reg <= '0;
    else
      out_reg <= out_next;
  end

  assign pin_out = out_reg;
endmodule : pin_sync
`default_nettype wire

// >>> core/burst_ddr_memory_interface.sv
// device side of a multi-bank burst ddr memory: commands, storage, data lanes
//
// Contract
// RULE1 - eight banks, chosen by bank address
// RULE2 - two data words per clock cycle
// RULE3 - read data aligned to driven data clock
// RULE4 - commands sampled on input clock rising edge
// RULE5 - write data captured on both clock edges
// RULE6 - burst length 2, 4 or 8
// RULE7 - refresh per bank, row counted internally
// RULE8 - fewer column bits as burst grows
// RULE9 - chip select high ignores new commands
// RULE10 - wide lanes use separate write clocks
// RULE11 - burst of N takes N/2 cycles
// RULE12 - controller captures reads with data clock
`default_nettype none
module burst_ddr_memory_interface (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic link_ck,
  input wire logic [1:0] write_data_clock,
  input wire ddr_burst_pkg::cmd_pins_type cmd_pins,
  input wire logic [ddr_burst_pkg::DQ_W-1:0] dq_in,
  output logic [ddr_burst_pkg::DQ_W-1:0] dq_out,
  output logic dq_oe,
  output logic [1:0] read_data_clock,
  output logic data_valid,
  output logic [ddr_burst_pkg::ROW_W-1:0] refresh_row
);
  import ddr_burst_pkg::*;

  // ==========================================================
  // pin sampling
  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_out;
  logic ck_s;
  logic [1:0] wdk_s;
  cmd_pins_type cmd_s;
  logic [DQ_W-1:0] dq_s;

  assign sync_in = {link_ck, write_data_clock, cmd_pins, dq_in};

  pin_sync #(.WIDTH(SYNC_W)) u_pin_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin_in(sync_in),
    .pin_out(sync_out)
  );

  assign {ck_s, wdk_s, cmd_s, dq_s} = sync_out;

  // ==========================================================
  // edge detection and command decode
  logic ck_prev_reg;
  logic [1:0] wdk_prev_reg;
  logic ck_rise;
  logic ck_edge;
  logic [1:0] lane_edge;
  logic take;
  logic [1:0] op;
  logic idle;
  logic take_read;
  logic take_write;
  logic take_mode;
  logic take_ref;
  burst_state_type state_reg;
  burst_state_type state_next;

  assign ck_rise = ck_s & ~ck_prev_reg; // RULE4
  assign ck_edge = ck_s ^ ck_prev_reg;
  assign lane_edge = wdk_s ^ wdk_prev_reg; // RULE5
  assign take = ck_rise & ~cmd_s.cs_n; // RULE9
  assign op = {cmd_s.we_n, cmd_s.ref_n};
  assign idle = state_reg == ST_IDLE;
  // a burst already running finishes; overlapping accesses are dropped
  assign take_read = take & (op == CMD_READ) & idle;
  assign take_write = take & (op == CMD_WRITE) & idle;
  assign take_mode = take & (op == CMD_MODE_SET) & idle;
  assign take_ref = take & (op == CMD_REFRESH);

  // ==========================================================
  // burst addressing
  logic [1:0] burst_code_reg;
  logic [1:0] mode_field;
  logic [BANK_W-1:0] bank_reg;
  logic [COL_W-1:0] col_reg;
  logic [BEAT_W-1:0] beat_reg;
  logic [BEAT_W-1:0] last_beat;
  logic beat_last;
  logic [WORD_W-1:0] word_idx;
  logic [MEM_W-1:0] mem_idx;
  logic [LANE_W-1:0] upper_hold_reg;
  logic [LANE_W-1:0] upper_word;
  logic [DQ_W-1:0] mem_reg [2**MEM_W];

  assign mode_field = cmd_s.addr[MR_BL_LSB +: 2];
  assign last_beat = (burst_code_reg == BL_CODE_8) ? LAST_BEAT_8 :
                     (burst_code_reg == BL_CODE_4) ? LAST_BEAT_4 : LAST_BEAT_2; // RULE6
  assign beat_last = beat_reg == last_beat;
  // low word bits come from the beat counter, not the address
  assign word_idx = (burst_code_reg == BL_CODE_8) ? {col_reg[0], beat_reg} :
                    (burst_code_reg == BL_CODE_4) ? {col_reg[1:0], beat_reg[1:0]} :
                    {col_reg, beat_reg[0]}; // RULE8
  assign mem_idx = {bank_reg, word_idx}; // RULE1
  // upper lane may clock in the same cycle as the lower one
  assign upper_word = lane_edge[1] ? dq_s[DQ_W-1:LANE_W] : upper_hold_reg; // RULE10

  // ==========================================================
  // burst sequencer
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:
        if (take_read)
          state_next = ST_READ;
        else if (take_write)
          state_next = ST_WRITE;
      ST_WRITE:
        if (lane_edge[0] && beat_last)
          state_next = ST_IDLE;
      ST_READ:
        if (ck_edge && beat_last)
          state_next = ST_TAIL; // RULE11
      ST_TAIL:
        if (ck_edge)
          state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_reg <= ST_IDLE;
      ck_prev_reg <= 1'b0;
      wdk_prev_reg <= 2'h0;
      read_data_clock <= 2'h0;
    end
    else
    begin
      state_reg <= state_next;
      ck_prev_reg <= ck_s;
      wdk_prev_reg <= wdk_s;
      read_data_clock <= {ck_s, ck_s}; // RULE3
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      burst_code_reg <= BL_RESET_CODE;
    else if (take_mode && mode_field != 2'h3)
      burst_code_reg <= mode_field; // RULE6
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      bank_reg <= '0;
      col_reg <= '0;
      beat_reg <= '0;
    end
    else if (take_read || take_write)
    begin
      bank_reg <= cmd_s.bank; // RULE1
      col_reg <= cmd_s.addr[COL_W-1:0];
      beat_reg <= '0;
    end
    else if ((state_reg == ST_WRITE && lane_edge[0]) || (state_reg == ST_READ && ck_edge))
      beat_reg <= beat_reg + 3'h1;
  end

  // ==========================================================
  // write lanes
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      upper_hold_reg <= '0;
    else if (lane_edge[1])
      upper_hold_reg <= dq_s[DQ_W-1:LANE_W]; // RULE10
  end

  // storage has no reset: contents are undefined until written
  always_ff @(posedge ref_clk)
  begin
    if (state_reg == ST_WRITE && lane_edge[0])
      mem_reg[mem_idx] <= {upper_word, dq_s[LANE_W-1:0]}; // RULE5
  end

  // ==========================================================
  // read lanes: one word per input clock edge
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      dq_out <= '0;
      data_valid <= 1'b0;
    end
    else if (state_reg == ST_READ && ck_edge)
    begin
      dq_out <= mem_reg[mem_idx]; // RULE2
      data_valid <= 1'b1;
    end
    else if (state_reg == ST_TAIL && ck_edge)
      data_valid <= 1'b0;
  end

  assign dq_oe = data_valid;

  // ==========================================================
  // per-bank refresh rows
  logic [ROW_W-1:0] row_cnt_reg [NUM_BANKS];

  for (genvar b = 0; b < NUM_BANKS; b++)
  begin : g_bank
    always_ff @(posedge ref_clk)
    begin
      if (sys_rst)
        row_cnt_reg[b] <= '0;
      else if (take_ref && cmd_s.bank == BANK_W'(b))
        row_cnt_reg[b] <= row_cnt_reg[b] + 4'h1; // RULE7
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      refresh_row <= '0;
    else if (take_ref)
      refresh_row <= row_cnt_reg[cmd_s.bank]; // RULE7
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  AST_BANK_LATCH: assert property (take_read |=> bank_reg == $past(cmd_s.bank)) // RULE1
    else $error("bank not latched from read command");
  AST_WORD_PER_EDGE: assert property (state_reg == ST_READ && ck_edge // RULE2
    |=> data_valid && dq_out == $past(mem_reg[mem_idx]))
    else $error("read word not presented on clock edge");
  AST_DATA_CLOCK: assert property (ck_edge // RULE3
    |=> read_data_clock[0] != $past(read_data_clock[0]))
    else $error("read data clock did not follow input clock");
  AST_CS_IGNORE: assert property (ck_rise && cmd_s.cs_n && idle |=> idle) // RULE9
    else $error("command taken while deselected");
  AST_RISE_ONLY: assert property (idle && !ck_rise |=> idle) // RULE4
    else $error("burst started off a rising edge");
  AST_WRITE_BEAT: assert property (state_reg == ST_WRITE && lane_edge[0] && !beat_last // RULE5
    |=> beat_reg == $past(beat_reg) + 3'h1)
    else $error("write beat not advanced on lane edge");
  AST_MODE_SET: assert property (take_mode && mode_field == BL_CODE_8 // RULE6
    |=> burst_code_reg == BL_CODE_8 ##1 last_beat == LAST_BEAT_8)
    else $error("burst length not programmed");
  // a refresh takes one cycle only, so check the bank's counter moved past the reported row
  AST_REFRESH_ROW: assert property (take_ref // RULE7
    |=> row_cnt_reg[$past(cmd_s.bank)] == refresh_row + 4'h1)
    else $error("refresh row did not advance");
  AST_COLUMN_BITS: assert property (burst_code_reg == BL_CODE_8 // RULE8
    |-> word_idx[BEAT_W-1:0] == beat_reg)
    else $error("column bits used under long burst");
  AST_BURST_END: assert property (state_reg == ST_READ && ck_edge && beat_last // RULE11
    |=> state_reg == ST_TAIL ##1 data_valid)
    else $error("read burst length wrong");
  AST_UPPER_LANE: assert property (lane_edge[1] // RULE10
    |=> upper_hold_reg == $past(dq_s[DQ_W-1:LANE_W]))
    else $error("upper lane not captured");

  COV_READ: cover property (take_read ##[1:200] state_reg == ST_TAIL);
  COV_WRITE: cover property (take_write ##[1:200] (state_reg == ST_WRITE && beat_last));
  COV_REFRESH: cover property (take_ref);
  COV_MODE8: cover property (take_mode && mode_field == BL_CODE_8);
endmodule : burst_ddr_memory_interface
`default_nettype wire

// >>> testbench/ctrl_model.sv
// controller model that drives the memory pins
`default_nettype none
module ctrl_model (
  input wire logic ref_clk,
  output logic link_ck,
  output logic [1:0] write_data_clock,
  output var ddr_burst_pkg::cmd_pins_type cmd_pins,
  output logic [ddr_burst_pkg::DQ_W-1:0] dq_in,
  input wire logic [1:0] read_data_clock,
  input wire logic data_valid,
  input wire logic [ddr_burst_pkg::DQ_W-1:0] dq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import ddr_burst_pkg::*;
  logic [DQ_W-1:0] rd_q[$];
  logic seen;
  logic grab;
  int ph;
  // ========
  // pins and free-running input clock
  initial
  begin
    link_ck = 1'b0;
    write_data_clock = 2'h0;
    dq_in = '0;
    cmd_pins = '1;
    ph = 0;
    seen = 1'b0;
    grab = 1'b0;
  end
  always @(negedge ref_clk)
  begin
    ph <= ph + 1;
    if (ph % 4 == 3)
      link_ck <= ~link_ck;
  end
  // ========
  // capture one cycle after a data clock edge, so skew cannot race
  always @(negedge ref_clk)
  begin
    seen <= read_data_clock[0];
    grab <= seen != read_data_clock[0];
    if (grab && data_valid)
      rd_q.push_back(dq_out);
  end
  // ========
  // command and write tasks
  task automatic send(input logic cs, input logic [1:0] op, input logic [BANK_W-1:0] bk,
    input logic [ADDR_W-1:0] ad);
    @(negedge link_ck);
    cmd_pins = {cs, op, bk, ad};
    @(negedge link_ck);
    cmd_pins.cs_n = 1'b1;
  endtask : send
  task automatic wburst(input int n, input logic [DQ_W-1:0] b);
    for (int i = 0; i < n; i++)
    begin
      dq_in = b + DQ_W'(i);
      repeat (3) @(negedge ref_clk);
      write_data_clock = ~write_data_clock;
      repeat (3) @(negedge ref_clk);
    end
    // released lines must not keep the last word
    dq_in = ~dq_in;
  endtask : wburst
endmodule : ctrl_model
`default_nettype wire

// >>> testbench/tb.sv
// self-checking bench for the burst ddr memory interface
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ddr_burst_pkg::*;
  logic ref_clk;
  logic sys_rst;
  logic link_ck;
  logic [1:0] write_data_clock;
  cmd_pins_type cmd_pins;
  logic [DQ_W-1:0] dq_in;
  logic [DQ_W-1:0] dq_out;
  logic dq_oe;
  logic [1:0] read_data_clock;
  logic data_valid;
  logic [ROW_W-1:0] refresh_row;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  // ref clock cycles per link half period in this bench
  localparam int LINK_HALF = 4;
  burst_ddr_memory_interface u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .link_ck(link_ck),
    .write_data_clock(write_data_clock), .cmd_pins(cmd_pins), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .read_data_clock(read_data_clock),
    .data_valid(data_valid), .refresh_row(refresh_row));
  ctrl_model u_ctrl (.ref_clk(ref_clk), .link_ck(link_ck),
    .write_data_clock(write_data_clock), .cmd_pins(cmd_pins), .dq_in(dq_in),
    .read_data_clock(read_data_clock), .data_valid(data_valid), .dq_out(dq_out));
  // ========
  // clock, timeout, reporting
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [DQ_W-1:0] got, input logic [DQ_W-1:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // ========
  // burst helpers
  task automatic wr(input logic [2:0] bk, input logic [21:0] ad, input int n,
    input logic [35:0] b);
    u_ctrl.send(1'b0, CMD_WRITE, bk, ad);
    u_ctrl.wburst(n, b);
  endtask : wr
  task automatic rd(input logic cs, input logic [2:0] bk, input logic [21:0] ad,
    input int n, input logic [35:0] b);
    int nv;
    int ne;
    nv = 0;
    ne = 0;
    u_ctrl.rd_q.delete();
    u_ctrl.send(cs, CMD_READ, bk, ad);
    // window covers the longest burst plus its tail with margin
    repeat (60)
    begin
      @(negedge ref_clk);
      nv += int'(data_valid === 1'b1);
      ne += int'(dq_oe === 1'b1);
    end
    chk(36'(nv), 36'(n * LINK_HALF));
    chk(36'(ne), 36'(n * LINK_HALF));
    chk(36'(u_ctrl.rd_q.size()), 36'(n));
    foreach (u_ctrl.rd_q[i])
      chk(u_ctrl.rd_q[i], b + 36'(i));
  endtask : rd
  task automatic mode(input logic [1:0] code);
    u_ctrl.send(1'b0, CMD_MODE_SET, 3'h0, {20'h0, code});
  endtask : mode
  // ========
  // scenarios
  task automatic t_reset();
    chk({dq_oe, data_valid, read_data_clock, refresh_row}, 36'h0);
  endtask : t_reset
  task automatic t_bursts();
    wr(3'h3, 22'h5, 2, 36'h9a5c33000);
    rd(1'b0, 3'h3, 22'h5, 2, 36'h9a5c33000);
    mode(BL_CODE_4);
    wr(3'h1, 22'h3, 4, 36'h3c0f1a000);
    rd(1'b0, 3'h1, 22'h3, 4, 36'h3c0f1a000);
    mode(BL_CODE_8);
    wr(3'h6, 22'h1, 8, 36'h5e1d07000);
    rd(1'b0, 3'h6, 22'h7, 8, 36'h5e1d07000);
  endtask : t_bursts
  task automatic t_banks();
    mode(2'h3);
    wr(3'h0, 22'h0, 8, 36'h111222000);
    wr(3'h7, 22'h0, 8, 36'h888999000);
    rd(1'b0, 3'h0, 22'h0, 8, 36'h111222000);
    rd(1'b0, 3'h7, 22'h0, 8, 36'h888999000);
    rd(1'b1, 3'h7, 22'h0, 0, 36'h0);
    mode(BL_CODE_2);
    rd(1'b0, 3'h3, 22'h5, 2, 36'h9a5c33000);
  endtask : t_banks
  task automatic t_refresh();
    int cnt[8];
    logic [2:0] bk[4] = '{3'h2, 3'h2, 3'h5, 3'h2};
    foreach (bk[i])
    begin
      u_ctrl.send(1'b0, CMD_REFRESH, bk[i], 22'h3fffff);
      repeat (4) @(negedge ref_clk);
      chk(36'(refresh_row), 36'(cnt[bk[i]]));
      cnt[bk[i]]++;
    end
  endtask : t_refresh
  task automatic t_rdclk();
    int t0;
    int t1;
    logic p;
    t0 = 0;
    t1 = 0;
    p = read_data_clock[0];
    repeat (80)
    begin
      @(negedge ref_clk);
      t0 += int'(read_data_clock[0] != p);
      t1 += int'(read_data_clock[1] !== read_data_clock[0]);
      p = read_data_clock[0];
    end
    chk(36'(t0), 36'h14);
    chk(36'(t1), 36'h0);
  endtask : t_rdclk
  initial
  begin
    sys_rst = 1'b1;
    repeat (4) @(negedge ref_clk);
    t_reset();
    @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (6) @(negedge ref_clk);
    t_bursts();
    t_banks();
    t_refresh();
    t_rdclk();
    complete_run();
  end
endmodule : tb
`default_nettype wire
